//--- core/pctb_pkg.sv
package pctb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Tail geometry
   localparam logic [4:0] PCTB_LEN_BASE     = 5'h16;
   localparam logic [4:0] PCTB_LEN_SEQ      = 5'h1A;
   localparam logic [4:0] PCTB_IDX_FLAG     = 5'h05;
   localparam logic [4:0] PCTB_IDX_RPM      = 5'h08;
   localparam logic [4:0] PCTB_IDX_TS       = 5'h0A;
   localparam logic [4:0] PCTB_IDX_MODE     = 5'h0E;
   localparam logic [4:0] PCTB_IDX_FACT     = 5'h0F;
   localparam logic [4:0] PCTB_IDX_DATE     = 5'h10;
   localparam logic [4:0] PCTB_IDX_SEQ      = 5'h16;

   ////////////////////////////////////////////////////////////////////////////
   // Field values
   localparam logic [7:0] PCTB_FLAG_HOT     = 8'h01;
   localparam logic [7:0] PCTB_FLAG_NORMAL  = 8'h00;
   localparam logic [7:0] PCTB_RESERVED     = 8'h00;
   // Arbitrary factory code
   localparam logic [7:0] PCTB_FACTORY_CODE = 8'h5A;
   localparam logic [7:0] PCTB_YEAR_BASE    = 8'h00;
   localparam logic [31:0] PCTB_US_MAX      = 32'h000F_4240;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned PCTB_CLK_MHZ     = 100;
   localparam int unsigned PCTB_US_CYCLES   = PCTB_CLK_MHZ;
   localparam int unsigned PCTB_SHUTDOWN_S  = 60;

   typedef enum logic [1:0] {
      PCTB_RET_STRONGEST = 2'b00,
      PCTB_RET_LAST      = 2'b01,
      PCTB_RET_DUAL      = 2'b10
   } pctb_ret_t;

   localparam logic [7:0] PCTB_CODE_STRONGEST = 8'h37;
   localparam logic [7:0] PCTB_CODE_LAST      = 8'h38;
   localparam logic [7:0] PCTB_CODE_DUAL      = 8'h39;

   typedef enum logic [1:0] {
      PCTB_ST_NORMAL   = 2'b00,
      PCTB_ST_COUNTING = 2'b01,
      PCTB_ST_SHUTDOWN = 2'b10
   } pctb_state_t;

   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } pctb_date_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } pctb_byte_t;

endpackage : pctb_pkg

//--- core/pctb_tail_builder.sv
`timescale 1ns/1ps
`default_nettype none

module pctb_tail_builder
   import pctb_pkg::*;
#(
   parameter int unsigned SHUTDOWN_S = PCTB_SHUTDOWN_S
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   // Configuration
   input  wire logic              seq_enable_in,
   input  wire pctb_pkg::pctb_ret_t ret_mode_in,
   input  wire logic [15:0]       motor_rpm_in,
   // Time base and sensor
   input  wire logic              pps_in,
   input  wire pctb_pkg::pctb_date_t date_in,
   input  wire logic              overheat_in,
   // Tail request and stream
   input  wire logic              start_in,
   input  wire logic              ready_in,
   output var  pctb_pkg::pctb_byte_t tail_out,
   output logic                   busy_out,
   // Status
   output logic                   hot_flag_out,
   output logic                   shutdown_out,
   output logic [31:0]            seq_count_out
);
   import pctb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [1:0] pps_sync_reg, hot_sync_reg;
   logic       pps_prev_reg;
   logic       pps_rise;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pps_sync_reg <= 2'b00;
         hot_sync_reg <= 2'b00;
         pps_prev_reg <= 1'b0;
      end else begin
         pps_sync_reg <= {pps_sync_reg[0], pps_in};
         hot_sync_reg <= {hot_sync_reg[0], overheat_in};
         pps_prev_reg <= pps_sync_reg[1];
      end
   end
   assign pps_rise = pps_sync_reg[1] & ~pps_prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Microsecond time base
   logic [6:0]  div_reg, div_next;
   logic [31:0] us_reg, us_next;
   logic        us_tick;
   assign us_tick = (div_reg == 7'(PCTB_US_CYCLES - 1));
   always_comb begin
      div_next = us_tick ? 7'h00 : div_reg + 7'h01;
      us_next  = us_reg;
      if (pps_rise) begin
         div_next = 7'h00;
         us_next  = 32'h0000_0000;
      end else if (us_tick && us_reg < PCTB_US_MAX) begin
         us_next  = us_reg + 32'h0000_0001;
      end
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         div_reg <= 7'h00;
         us_reg  <= 32'h0000_0000;
      end else begin
         div_reg <= div_next;
         us_reg  <= us_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overheat supervisor
   pctb_state_t st_reg, st_next;
   logic [31:0] sec_reg, sec_next;
   always_comb begin
      st_next  = st_reg;
      sec_next = sec_reg;
      case (st_reg)
         PCTB_ST_NORMAL: begin
            if (hot_sync_reg[1]) begin
               st_next  = PCTB_ST_COUNTING;
               sec_next = 32'h0000_0000;
            end
         end
         PCTB_ST_COUNTING: begin
            if (!hot_sync_reg[1]) begin
               st_next = PCTB_ST_NORMAL;
            end else if (pps_rise) begin
               sec_next = sec_reg + 32'h0000_0001;
               if (sec_next >= SHUTDOWN_S) begin
                  st_next = PCTB_ST_SHUTDOWN;
               end
            end
         end
         PCTB_ST_SHUTDOWN: begin
            if (!hot_sync_reg[1]) begin
               st_next = PCTB_ST_NORMAL;
            end
         end
         default: st_next = PCTB_ST_NORMAL;
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_reg  <= PCTB_ST_NORMAL;
         sec_reg <= 32'h0000_0000;
      end else begin
         st_reg  <= st_next;
         sec_reg <= sec_next;
      end
   end
   // Flag follows the synchronised condition, so it rises without waiting for the shutdown count
   assign hot_flag_out = hot_sync_reg[1];
   assign shutdown_out = (st_reg == PCTB_ST_SHUTDOWN);

   ////////////////////////////////////////////////////////////////////////////
   // Tail sequencer
   logic        act_reg, act_next;
   logic        seqon_reg, seqon_next;
   logic [4:0]  idx_reg, idx_next;
   logic [4:0]  len;
   logic [31:0] seq_reg, seq_next;
   logic [31:0] ts_reg, ts_next;
   logic [7:0]  flag_reg, flag_next, mode_reg, mode_next;
   logic [15:0] rpm_reg, rpm_next;
   pctb_date_t  date_reg, date_next;
   pctb_byte_t  out_reg, out_next;
   logic [7:0]  cur;
   logic        adv;

   assign len = seqon_reg ? PCTB_LEN_SEQ : PCTB_LEN_BASE;
   assign adv = !out_reg.valid || ready_in;

   // Byte selector, little endian multi-byte fields except the date, which is sent year first
   always_comb begin
      cur = PCTB_RESERVED;
      if (idx_reg == PCTB_IDX_FLAG) begin
         cur = flag_reg;
      end else if (idx_reg >= PCTB_IDX_RPM && idx_reg < PCTB_IDX_TS) begin
         cur = rpm_reg[8*(idx_reg[0]) +: 8];
      end else if (idx_reg >= PCTB_IDX_TS && idx_reg < PCTB_IDX_MODE) begin
         cur = ts_reg[8*(idx_reg - PCTB_IDX_TS) +: 8];
      end else if (idx_reg == PCTB_IDX_MODE) begin
         cur = mode_reg;
      end else if (idx_reg == PCTB_IDX_FACT) begin
         cur = PCTB_FACTORY_CODE;
      end else if (idx_reg >= PCTB_IDX_DATE && idx_reg < PCTB_IDX_SEQ) begin
         cur = date_reg[8*(5 - (idx_reg - PCTB_IDX_DATE)) +: 8];
      end else if (idx_reg >= PCTB_IDX_SEQ) begin
         cur = seq_reg[8*(idx_reg - PCTB_IDX_SEQ) +: 8];
      end
   end

   always_comb begin
      act_next   = act_reg;
      seqon_next = seqon_reg;
      idx_next   = idx_reg;
      seq_next   = seq_reg;
      ts_next    = ts_reg;
      flag_next  = flag_reg;
      mode_next  = mode_reg;
      rpm_next   = rpm_reg;
      date_next  = date_reg;
      out_next   = out_reg;
      if (out_reg.valid && ready_in) begin
         out_next.valid = 1'b0;
      end
      if (!act_reg && start_in) begin
         // Snapshot every field so the tail is self-consistent
         act_next   = 1'b1;
         idx_next   = 5'h00;
         seqon_next = seq_enable_in;
         ts_next    = us_reg;
         flag_next  = hot_flag_out ? PCTB_FLAG_HOT : PCTB_FLAG_NORMAL;
         rpm_next   = motor_rpm_in;
         date_next  = date_in;
         date_next.year = date_in.year - PCTB_YEAR_BASE;
         case (ret_mode_in)
            PCTB_RET_LAST: mode_next = PCTB_CODE_LAST;
            PCTB_RET_DUAL: mode_next = PCTB_CODE_DUAL;
            default:       mode_next = PCTB_CODE_STRONGEST;
         endcase
      end else if (act_reg && adv) begin
         out_next.valid = 1'b1;
         out_next.data  = cur;
         out_next.last  = (idx_reg == len - 5'h01);
         idx_next       = idx_reg + 5'h01;
         if (idx_reg == len - 5'h01) begin
            act_next = 1'b0;
            seq_next = seq_reg + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         act_reg   <= 1'b0;
         seqon_reg <= 1'b0;
         idx_reg   <= 5'h00;
         seq_reg   <= 32'h0000_0000;
         ts_reg    <= 32'h0000_0000;
         flag_reg  <= PCTB_FLAG_NORMAL;
         mode_reg  <= PCTB_CODE_STRONGEST;
         rpm_reg   <= 16'h0000;
         date_reg  <= '0;
         out_reg   <= '0;
      end else begin
         act_reg   <= act_next;
         seqon_reg <= seqon_next;
         idx_reg   <= idx_next;
         seq_reg   <= seq_next;
         ts_reg    <= ts_next;
         flag_reg  <= flag_next;
         mode_reg  <= mode_next;
         rpm_reg   <= rpm_next;
         date_reg  <= date_next;
         out_reg   <= out_next;
      end
   end

   assign tail_out      = out_reg;
   assign busy_out      = act_reg || out_reg.valid;
   assign seq_count_out = seq_reg;

endmodule : pctb_tail_builder

`default_nettype wire

//--- verification/pctb_tail_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pctb_tail_chk
   import pctb_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   // Watched ports
   input  wire logic                 start_in,
   input  wire logic                 ready_in,
   input  wire logic                 overheat_in,
   input  wire pctb_pkg::pctb_byte_t tail_out,
   input  wire logic                 busy_out,
   input  wire logic                 hot_flag_out,
   input  wire logic                 shutdown_out,
   input  wire logic [31:0]          seq_count_out
);
   logic [4:0] idx_reg;
   logic [4:0] idx_next;
   logic       take;
   assign take = tail_out.valid && ready_in;
   // Byte position within the tail
   always_comb begin
      idx_next = idx_reg;
      if (take)
         idx_next = tail_out.last ? 5'h00 : idx_reg + 5'h01;
   end
   always_ff @(posedge clk_in) begin
      idx_reg <= rst_in ? 5'h00 : idx_next;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_answer;
      busy_out ##1 tail_out.valid;
   endsequence
   a_start_answer: assert property (start_in && !busy_out |=> s_answer)
      else $error("no tail after start");
   a_flag_rise: assert property ($rose(overheat_in) |-> ##[1:3] hot_flag_out)
      else $error("flag not set");
   a_flag_fall: assert property ($fell(overheat_in) |-> ##[1:3] !hot_flag_out)
      else $error("flag not cleared");
   a_shut_hot: assert property (shutdown_out |-> hot_flag_out || $past(hot_flag_out))
      else $error("shutdown without flag");
   a_hold_stall: assert property (tail_out.valid && !ready_in |=> $stable(tail_out))
      else $error("byte changed while stalled");
   a_tail_len: assert property (take && tail_out.last |-> idx_reg inside {5'h15, 5'h19})
      else $error("bad tail length");
   a_reserved_zero: assert property (tail_out.valid
      && idx_reg inside {[5'h00:5'h04], 5'h06, 5'h07} |-> tail_out.data == PCTB_RESERVED)
      else $error("reserved byte not zero");
   a_mode_code: assert property (tail_out.valid && idx_reg == PCTB_IDX_MODE
      |-> tail_out.data inside {8'h37, 8'h38, 8'h39})
      else $error("bad mode code");
   a_flag_code: assert property (tail_out.valid && idx_reg == PCTB_IDX_FLAG
      |-> tail_out.data inside {8'h00, 8'h01})
      else $error("bad flag byte");
   a_seq_step: assert property (seq_count_out != $past(seq_count_out)
      |-> seq_count_out == $past(seq_count_out) + 32'h1)
      else $error("sequence did not step by one");
endmodule : pctb_tail_chk
bind pctb_tail_builder pctb_tail_chk i_chk (.clk_in, .rst_in, .start_in, .ready_in, .overheat_in,
   .tail_out, .busy_out, .hot_flag_out, .shutdown_out, .seq_count_out);
`default_nettype wire

//--- verification/pctb_host.sv
`timescale 1ns/1ps
`default_nettype none
module pctb_host
   import pctb_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   // Tail stream
   input  wire pctb_pkg::pctb_byte_t tail_in,
   input  wire logic                 stall_in,
   output var  logic                 ready_out
);
   localparam int unsigned DIST_UNIT_MM = 4;
   logic [7:0] rx_q[$];
   // Point distance from a raw measurement
   function automatic int unsigned dist_mm(input int unsigned raw);
      return raw * DIST_UNIT_MM;
   endfunction : dist_mm
   // Angles in micro-degrees; rpm times six is micro-degrees per microsecond
   function automatic longint fire_udeg(input int unsigned fire_us, input int unsigned rpm);
      return longint'(fire_us) * rpm * 6;
   endfunction : fire_udeg
   // Y axis is zero, clockwise positive
   function automatic longint h_angle_udeg(input longint azim, input longint ch_off,
                                           input longint fire);
      return azim + ch_off + fire;
   endfunction : h_angle_udeg
   // Channels numbered from one, top row first; zero elevation is horizontal
   function automatic int unsigned chan_num(input int unsigned row);
      return row + 1;
   endfunction : chan_num
   // Every other cycle ready while stalling
   always @(posedge clk_in) begin
      ready_out <= rst_in ? 1'b0 : (stall_in ? ~ready_out : 1'b1);
      if (!rst_in && tail_in.valid && ready_out)
         rx_q.push_back(tail_in.data);
   end
endmodule : pctb_host
`default_nettype wire

//--- verification/point_cloud_packet_tail_builder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module point_cloud_packet_tail_builder_tb;
   import pctb_pkg::*;
   logic        clk_in, rst_in, start_in, ready_in, pps_in, overheat_in, seq_enable_in;
   logic        busy_out, hot_flag_out, shutdown_out, stall;
   pctb_ret_t   ret_mode_in;
   pctb_date_t  date_in;
   pctb_byte_t  tail_out;
   logic [15:0] motor_rpm_in;
   logic [31:0] seq_count_out;
   logic [31:0] n_pkt = 32'h0;
   int          miscompares = 0;
   int          n_tests = 0;
   int          m;
   pctb_tail_builder #(.SHUTDOWN_S(2)) i_dut (.clk_in, .rst_in, .seq_enable_in, .ret_mode_in,
      .motor_rpm_in, .pps_in, .date_in, .overheat_in, .start_in, .ready_in, .tail_out,
      .busy_out, .hot_flag_out, .shutdown_out, .seq_count_out);
   pctb_host i_host (.clk_in, .rst_in, .tail_in(tail_out), .stall_in(stall), .ready_out(ready_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("Compares %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   // Request one tail and compare every field
   task automatic get_tail(input logic hot, input logic [7:0] code);
      logic [7:0] q[$];
      int i;
      i_host.rx_q.delete();
      @(posedge clk_in) start_in <= 1'b1;
      @(posedge clk_in) start_in <= 1'b0;
      for (i = 0; i < 100 && (busy_out || i < 2); i++) @(posedge clk_in) #1;
      q = i_host.rx_q;
      chk(q.size(), seq_enable_in ? 26 : 22);
      for (i = 0; i < 8; i++) chk(q[i], i == 5 ? {7'h00, hot} : 8'h00);
      chk({q[9], q[8]}, motor_rpm_in);
      chk({q[13], q[12], q[11], q[10]} <= PCTB_US_MAX, 1'b1);
      chk(q[14], code);
      chk(q[15], PCTB_FACTORY_CODE);
      chk({q[16], q[17], q[18], q[19], q[20], q[21]}, date_in);
      if (seq_enable_in)
         chk({q[25], q[24], q[23], q[22]}, n_pkt);
      n_pkt++;
      @(posedge clk_in);
   endtask : get_tail
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      #100us;
      miscompares++;
      test_done();
   end
   initial begin
      rst_in = 1'b1;
      start_in = 1'b0;
      pps_in = 1'b0;
      overheat_in = 1'b0;
      seq_enable_in = 1'b0;
      stall = 1'b0;
      ret_mode_in = PCTB_RET_STRONGEST;
      motor_rpm_in = 16'h04B0;
      date_in = {8'h18, 8'h0C, 8'h1F, 8'h17, 8'h3B, 8'h3B};
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      get_tail(1'b0, PCTB_CODE_STRONGEST);
      chk(i_host.dist_mm(32'h0000_00FA), 48'h3E8);
      chk(i_host.fire_udeg(32'h3, {i_host.rx_q[9], i_host.rx_q[8]}), 48'h5460);
      chk(i_host.h_angle_udeg(64'hF_4240, 64'hA410, 64'h5460), 48'h10_3AB0);
      chk(i_host.chan_num(32'h0), 48'h1);
      seq_enable_in <= 1'b1;
      stall <= 1'b1;
      for (m = 0; m < 3; m++) begin
         ret_mode_in <= pctb_ret_t'(m);
         get_tail(1'b0, 8'h37 + 8'(m));
      end
      ret_mode_in <= pctb_ret_t'(2'b11);
      get_tail(1'b0, PCTB_CODE_STRONGEST);
      ret_mode_in <= PCTB_RET_DUAL;
      overheat_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      #1 chk(hot_flag_out, 1'b1);
      for (m = 0; m < 2; m++) begin
         @(posedge clk_in) pps_in <= 1'b1;
         repeat (5) @(posedge clk_in);
         pps_in <= 1'b0;
         repeat (20) @(posedge clk_in);
         #1 chk({hot_flag_out, shutdown_out}, {1'b1, m > 0});
      end
      get_tail(1'b1, 8'h39);
      chk({i_host.rx_q[13], i_host.rx_q[12], i_host.rx_q[11], i_host.rx_q[10]}, 32'h0);
      overheat_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      #1 chk({hot_flag_out, shutdown_out}, 2'b00);
      get_tail(1'b0, 8'h39);
      #1 chk(seq_count_out, n_pkt);
      test_done();
   end
endmodule : point_cloud_packet_tail_builder_tb
`default_nettype wire
